// *** rscc_params.svh ***
// offsets, field positions, reset values and counts for the radio
// state control block; included by the control state machine file only
`ifndef RSCC_PARAMS_SVH
`define RSCC_PARAMS_SVH

// register offsets on the configuration port
`define RSCC_ADDR_CHAN_PKT   6'h16
`define RSCC_ADDR_CAL_PWR    6'h17

// channel_and_packet_end_control field positions
`define RSCC_CCA_LSB         4
`define RSCC_RXOFF_LSB       2
`define RSCC_TXOFF_LSB       0
// calibration_and_powerup_control field positions
`define RSCC_AUTOCAL_LSB     4
`define RSCC_PO_LSB          2

// reset values of the six stored bits of each register
`define RSCC_CHAN_PKT_RST    6'h30
`define RSCC_CAL_PWR_RST     6'h04

// expiry counts selected by the power-up field
`define RSCC_PO_EXP_0        9'h001
`define RSCC_PO_EXP_1        9'h010
`define RSCC_PO_EXP_2        9'h040
`define RSCC_PO_EXP_3        9'h100

// six-bit synchronous expiry counter width and calibration length in clk cycles
`define RSCC_EXPIRY_BITS     6
`define RSCC_CAL_CYCLES      16

`endif

// *** rscc_pkg.sv ***
// types shared by the radio state control block
// does not include rscc_params.svh and needs nothing from it
package rscc_pkg;

  // one-hot radio states
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_cal  = 5'h02,
    st_rx   = 5'h04,
    st_tx   = 5'h08,
    st_fstx = 5'h10
  } rscc_state_type;

  // one-cycle command strobes from the host command decoder
  typedef struct packed {
    logic go_rx;
    logic go_tx;
    logic go_fstx;
    logic go_idle;
    logic synth_calibrate_strobe;
  } rscc_cmd_type;

  // status from modem and packet handler, same clock
  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic rssi_below;
    logic rx_busy;
  } rscc_modem_type;

endpackage

// *** rscc_expiry.sv ***
// six-bit expiry counter for the power-up timeout
// assumes run is a same-clock level; counter clears while run is low
`timescale 1ns/1ps
module rscc_expiry #(
  parameter int WIDTH = 6
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      expire
);
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic             next_expire;

  // count while running, pulse on wrap
  always_comb begin
    next_cnt    = run ? cnt + 1'b1 : '0;
    next_expire = run && (&cnt);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt    <= '0;
      expire <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      expire <= next_expire;
    end
  end
endmodule

// *** rscc_ctrl.sv ***
// radio main control state machine with its two configuration registers
// assumes one-cycle host strobes and same-clock modem status
// How it works
// - clear_channel_flag per select: always, rssi low, not receiving, both.
// - after a received packet the next state is idle, fstx, tx or stay in rx.
// - after a sent packet the next state is idle, fstx, stay in tx, or rx.
// - with autocal 00 calibration runs only on the manual calibrate strobe.
// - with autocal 01 every idle to rx, tx or fstx passes through calibration.
// - with autocal 10 every return from rx or tx to idle calibrates.
// - with autocal 11 only every fourth return to idle calibrates.
// - chip_ready_n stays high until the expiry count after crystal stable.
// - power-up settings 0..3 need 1, 16, 64 and 256 expiries.
// - crystal_stable rises in the cycle chip_ready_n falls.
`timescale 1ns/1ps
`include "rscc_params.svh"
module rscc_ctrl import rscc_pkg::*; #(
  parameter int EXP_WIDTH  = `RSCC_EXPIRY_BITS,
  parameter int CAL_CYCLES = `RSCC_CAL_CYCLES
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic [5:0]     reg_addr,
  input  wire logic           reg_wr,
  input  wire logic [7:0]     reg_wdata,
  output logic      [7:0]     reg_rdata,
  input  wire rscc_cmd_type   cmd,
  input  wire rscc_modem_type modem,
  input  wire logic           crystal_oscillator_ok,
  output logic                chip_ready_n,
  output logic                crystal_stable,
  output logic                clear_channel_flag,
  output rscc_state_type      radio_state
);
  logic [5:0]     chan_pkt, next_chan_pkt;
  logic [5:0]     cal_pwr, next_cal_pwr;
  logic [7:0]     next_rdata;
  logic [1:0]     clear_channel_select, after_receive_next_state;
  logic [1:0]     after_transmit_next_state, synth_autocal_policy;
  logic [1:0]     powerup_expiry_select;
  logic           next_cca;

  assign clear_channel_select      = chan_pkt[`RSCC_CCA_LSB +: 2];
  assign after_receive_next_state  = chan_pkt[`RSCC_RXOFF_LSB +: 2];
  assign after_transmit_next_state = chan_pkt[`RSCC_TXOFF_LSB +: 2];
  assign synth_autocal_policy      = cal_pwr[`RSCC_AUTOCAL_LSB +: 2];
  assign powerup_expiry_select     = cal_pwr[`RSCC_PO_LSB +: 2];

  // register writes, read mux and clear channel indication
  always_comb begin
    next_chan_pkt = chan_pkt;
    next_cal_pwr  = cal_pwr;
    if (reg_wr && reg_addr == `RSCC_ADDR_CHAN_PKT)
      next_chan_pkt = reg_wdata[5:0];
    if (reg_wr && reg_addr == `RSCC_ADDR_CAL_PWR)
      next_cal_pwr = reg_wdata[5:0];
    case (reg_addr)
      `RSCC_ADDR_CHAN_PKT: next_rdata = {2'h0, chan_pkt};
      `RSCC_ADDR_CAL_PWR:  next_rdata = {2'h0, cal_pwr};
      default:             next_rdata = 8'h00;
    endcase
    case (clear_channel_select)
      2'h0:    next_cca = 1'b1;
      2'h1:    next_cca = modem.rssi_below;
      2'h2:    next_cca = !modem.rx_busy;
      default: next_cca = modem.rssi_below && !modem.rx_busy;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_pkt           <= `RSCC_CHAN_PKT_RST;
      cal_pwr            <= `RSCC_CAL_PWR_RST;
      reg_rdata          <= 8'h00;
      clear_channel_flag <= 1'b1;
    end else begin
      chan_pkt           <= next_chan_pkt;
      cal_pwr            <= next_cal_pwr;
      reg_rdata          <= next_rdata;
      clear_channel_flag <= next_cca;
    end
  end

  // crystal stable pin: three flops, change taken when last two agree
  logic xs1, xs2, xs3, xs_filt, next_xs_filt;
  logic [8:0] exp_cnt, next_exp_cnt, exp_target;
  logic       exp_pulse, next_ready_n;

  always_comb begin
    next_xs_filt = (xs2 == xs3) ? xs3 : xs_filt;
    case (powerup_expiry_select)
      2'h0:    exp_target = `RSCC_PO_EXP_0;
      2'h1:    exp_target = `RSCC_PO_EXP_1;
      2'h2:    exp_target = `RSCC_PO_EXP_2;
      default: exp_target = `RSCC_PO_EXP_3;
    endcase
    next_exp_cnt = exp_cnt;
    next_ready_n = chip_ready_n;
    if (!xs_filt) begin
      next_exp_cnt = 9'h000;
      next_ready_n = 1'b1;
    end else if (chip_ready_n && exp_pulse) begin
      next_exp_cnt = exp_cnt + 9'h001;
      if (exp_cnt + 9'h001 >= exp_target)
        next_ready_n = 1'b0;
    end
  end

  rscc_expiry #(.WIDTH(EXP_WIDTH)) u_expiry (
    .clk    (clk),
    .rst_n  (rst_n),
    .run    (xs_filt && chip_ready_n),
    .expire (exp_pulse)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xs1            <= 1'b0;
      xs2            <= 1'b0;
      xs3            <= 1'b0;
      xs_filt        <= 1'b0;
      exp_cnt        <= 9'h000;
      chip_ready_n   <= 1'b1;
      crystal_stable <= 1'b0;
    end else begin
      xs1            <= crystal_oscillator_ok;
      xs2            <= xs1;
      xs3            <= xs2;
      xs_filt        <= next_xs_filt;
      exp_cnt        <= next_exp_cnt;
      chip_ready_n   <= next_ready_n;
      crystal_stable <= !next_ready_n;
    end
  end

  // main state machine with calibration insertion
  rscc_state_type next_state, after_cal, next_after_cal, go_to;
  logic [1:0] ret_cnt, next_ret_cnt;
  logic [7:0] cal_timer, next_cal_timer;
  logic       to_idle;

  always_comb begin
    next_state     = radio_state;
    next_after_cal = after_cal;
    next_ret_cnt   = ret_cnt;
    next_cal_timer = 8'h00;
    to_idle        = 1'b0;
    go_to          = st_idle;
    case (radio_state)
      st_idle: begin
        if (cmd.go_rx)        go_to = st_rx;
        else if (cmd.go_tx)   go_to = st_tx;
        else if (cmd.go_fstx) go_to = st_fstx;
        if (chip_ready_n) begin
          next_state = st_idle;
        end else if (cmd.synth_calibrate_strobe) begin
          next_state     = st_cal;
          next_after_cal = st_idle;
        end else if (go_to != st_idle) begin
          if (synth_autocal_policy == 2'h1) begin
            next_state     = st_cal;
            next_after_cal = go_to;
          end else begin
            next_state = go_to;
          end
        end
      end
      st_cal: begin
        next_cal_timer = cal_timer + 8'h01;
        if (cal_timer == 8'(CAL_CYCLES - 1))
          next_state = after_cal;
      end
      st_rx: begin
        if (cmd.go_idle) to_idle = 1'b1;
        else if (modem.rx_done) begin
          case (after_receive_next_state)
            2'h0:    to_idle = 1'b1;
            2'h1:    next_state = st_fstx;
            2'h2:    next_state = st_tx;
            default: next_state = st_rx;
          endcase
        end
      end
      st_tx: begin
        if (cmd.go_idle) to_idle = 1'b1;
        else if (modem.tx_done) begin
          case (after_transmit_next_state)
            2'h0:    to_idle = 1'b1;
            2'h1:    next_state = st_fstx;
            2'h2:    next_state = st_tx;
            default: next_state = st_rx;
          endcase
        end
      end
      st_fstx: begin
        if (cmd.go_idle)    next_state = st_idle;
        else if (cmd.go_tx) next_state = st_tx;
        else if (cmd.go_rx) next_state = st_rx;
      end
      default: next_state = st_idle;
    endcase
    // return to idle, calibrating per policy
    if (to_idle) begin
      next_state     = st_idle;
      next_after_cal = st_idle;
      if (synth_autocal_policy == 2'h2) begin
        next_state = st_cal;
      end else if (synth_autocal_policy == 2'h3) begin
        next_ret_cnt = ret_cnt + 2'h1;
        if (ret_cnt == 2'h3)
          next_state = st_cal;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      radio_state <= st_idle;
      after_cal   <= st_idle;
      ret_cnt     <= 2'h0;
      cal_timer   <= 8'h00;
    end else begin
      radio_state <= next_state;
      after_cal   <= next_after_cal;
      ret_cnt     <= next_ret_cnt;
      cal_timer   <= next_cal_timer;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_cca_always: assert property (
    clear_channel_select == 2'h0 |=> clear_channel_flag)
    else $error("clear channel not set in always mode");
  chk_cca_both: assert property (
    clear_channel_select == 2'h3 && (!modem.rssi_below || modem.rx_busy)
    |=> !clear_channel_flag)
    else $error("clear channel set while busy or loud");
  chk_rx_end_idle: assert property (
    radio_state == st_rx && modem.rx_done && !cmd.go_idle &&
    after_receive_next_state == 2'h0 && synth_autocal_policy == 2'h0
    |=> radio_state == st_idle)
    else $error("no return to idle after reception");
  chk_tx_restart: assert property (
    radio_state == st_tx && modem.tx_done && !cmd.go_idle &&
    after_transmit_next_state == 2'h2 |=> radio_state == st_tx [*2])
    else $error("left transmit despite stay setting");
  chk_no_autocal: assert property (
    radio_state != st_cal && synth_autocal_policy == 2'h0 &&
    !cmd.synth_calibrate_strobe |=> radio_state != st_cal)
    else $error("calibration without strobe");
  chk_cal_on_start: assert property (
    radio_state == st_idle && !chip_ready_n && cmd.go_rx &&
    !cmd.synth_calibrate_strobe && synth_autocal_policy == 2'h1
    |=> radio_state == st_cal ##CAL_CYCLES radio_state == st_rx)
    else $error("start did not calibrate then receive");
  chk_cal_on_return: assert property (
    (radio_state == st_rx || radio_state == st_tx) && cmd.go_idle &&
    synth_autocal_policy == 2'h2 |=> radio_state == st_cal)
    else $error("return to idle without calibration");
  chk_every_fourth: assert property (
    to_idle && synth_autocal_policy == 2'h3
    |=> radio_state == ($past(ret_cnt) == 2'h3 ? st_cal : st_idle))
    else $error("fourth-return calibration wrong");
  chk_ready_count: assert property (
    $fell(chip_ready_n) |-> $past(exp_pulse) &&
    $past(exp_cnt) + 9'h001 >= $past(exp_target))
    else $error("ready before expiry count");
  chk_ready_together: assert property (
    crystal_stable == !chip_ready_n)
    else $error("crystal stable and ready disagree");
  chk_unused_zero: assert property (
    reg_rdata[7:6] == 2'h0)
    else $error("unused register bits read nonzero");

  cov_ready: cover property ($fell(chip_ready_n));
  cov_cal_rx: cover property (radio_state == st_cal ##1 radio_state == st_rx);
  cov_rx_tx: cover property (radio_state == st_rx ##1 radio_state == st_tx);
  cov_fourth: cover property (to_idle && ret_cnt == 2'h3 &&
    synth_autocal_policy == 2'h3);
endmodule

// *** rscc_host.sv ***
// host model: writes and reads the two configuration registers
// assumes the bench clock; drives on the falling edge
`timescale 1ns/1ps
module rscc_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [5:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // one-cycle write; data line scrambled once released
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  // read data is registered, so take it one cycle later
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule

// *** rscc_ctrl_tb.sv ***
// self-checking bench for the radio state control block
// assumes rscc_host owns the register port
`timescale 1ns/1ps
module rscc_ctrl_tb import rscc_pkg::*; ;
  logic           clk = 1'b0;
  logic           rst_n;
  logic           xo_ok;
  logic [5:0]     reg_addr;
  logic           reg_wr;
  logic [7:0]     reg_wdata;
  logic [7:0]     reg_rdata;
  logic [7:0]     rv;
  rscc_cmd_type   cmd;
  rscc_modem_type modem;
  logic           chip_ready_n;
  logic           crystal_stable;
  logic           clear_channel_flag;
  rscc_state_type radio_state;
  int             err_count;
  int             num_checks;
  int             n;
  int             bad;
  rscc_state_type nxt [4] = '{st_idle, st_fstx, st_tx, st_rx};

  rscc_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata));

  rscc_ctrl #(.EXP_WIDTH(2), .CAL_CYCLES(4)) dut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cmd(cmd), .modem(modem),
    .crystal_oscillator_ok(xo_ok), .chip_ready_n(chip_ready_n),
    .crystal_stable(crystal_stable),
    .clear_channel_flag(clear_channel_flag), .radio_state(radio_state));

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // command and done pulses, one cycle each
  task automatic go(input logic [4:0] c, input logic [1:0] d);
    @(negedge clk);
    cmd = c;
    modem[3:2] = d;
    @(negedge clk);
    cmd = '0;
    modem[3:2] = 2'b00;
  endtask

  // reset, optional power-up setting, then time chip ready
  task automatic rst(input logic [7:0] cfg, input int tgt);
    rst_n = 1'b0;
    xo_ok = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    if (cfg !== 8'h04) host.wr(6'h17, cfg);
    @(negedge clk);
    xo_ok = 1'b1;
    n = 0;
    bad = 0;
    while (chip_ready_n !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
      if (crystal_stable !== !chip_ready_n) bad++;
    end
    chk("powerup", (n >= tgt * 4 && n <= tgt * 4 + 8), 8'h01);
    chk("xtal_stable", bad[7:0], 8'h00);
  endtask

  // calibration spans four cycles before the target state
  task automatic cal(input rscc_state_type t);
    chk("cal", radio_state, st_cal);
    repeat (4) @(negedge clk);
    chk("after_cal", radio_state, t);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // watchdog
  initial begin
    #400000;
    err_count++;
    conclude();
  end

  initial begin
    err_count = 0;
    num_checks = 0;
    cmd = '0;
    modem = '0;
    rst(8'h04, 16);
    host.rd(6'h16, rv);
    chk("reg16", rv, 8'h30);
    host.rd(6'h17, rv);
    chk("reg17", rv, 8'h04);
    host.wr(6'h16, 8'hff);
    host.rd(6'h16, rv);
    chk("reg16", rv, 8'h3f);
    host.wr(6'h20, 8'hff);
    host.rd(6'h20, rv);
    chk("unmapped", rv, 8'h00);
    // every select against every rssi and busy level
    for (int s = 0; s < 16; s++) begin
      host.wr(6'h16, {2'b00, s[3:2], 4'h0});
      modem[1:0] = s[1:0];
      repeat (3) @(negedge clk);
      chk("cca", clear_channel_flag,
        (!s[2] || s[1]) && (!s[3] || !s[0]));
    end
    modem = '0;
    // after-packet states in both directions
    for (int m = 0; m < 4; m++) begin
      host.wr(6'h16, {4'h0, m[1:0], m[1:0]});
      go(5'h10, 2'b00);
      chk("rx", radio_state, st_rx);
      go(5'h00, 2'b10);
      chk("after_rx", radio_state, nxt[m]);
      go(5'h02, 2'b00);
      go(5'h08, 2'b00);
      go(5'h00, 2'b01);
      chk("after_tx", radio_state, nxt[m]);
      go(5'h02, 2'b00);
    end
    go(5'h01, 2'b00);
    cal(st_idle);
    host.wr(6'h16, 8'h00);
    host.wr(6'h17, 8'h14);
    go(5'h10, 2'b00);
    cal(st_rx);
    go(5'h02, 2'b00);
    go(5'h04, 2'b00);
    cal(st_fstx);
    go(5'h02, 2'b00);
    host.wr(6'h17, 8'h24);
    go(5'h08, 2'b00);
    chk("tx", radio_state, st_tx);
    go(5'h00, 2'b01);
    cal(st_idle);
    // abort from receive also calibrates on the way back to idle
    go(5'h10, 2'b00);
    chk("rx7", radio_state, st_rx);
    go(5'h02, 2'b00);
    cal(st_idle);
    rst(8'h30, 1);
    for (int i = 1; i <= 4; i++) begin
      go(5'h10, 2'b00);
      chk("rx4", radio_state, st_rx);
      go(5'h02, 2'b00);
      if (i < 4)
        chk("idle4", radio_state, st_idle);
      else
        cal(st_idle);
    end
    rst(8'h08, 64);
    rst(8'h0c, 256);
    conclude();
  end
endmodule
